// [verilog/bts_transfer_logic.sv]
// Automatic bus transfer logic for incomer or bus tie role
// Summary of operation
// - Role setting selects off, incomer or tie
// - Guard delays 0 to 10 s, 0.1 s
// - Double loss inhibit suppresses timed undervoltage trips
// - No transfer close after double source loss
// - Lockout, upstream trip or undervoltage start transfer
// - Block if any breaker not connected
// - Block while other incomer is open
// - Block during own bus instantaneous overcurrent
// - Block while other source undervoltage operated
// - Hold trip and close until own breaker opens
// - Tie latches close until closed or inhibit
// - Tie closes only with sync check permit
// - Third breaker closing trips the chosen breaker
// - This-source window after overcurrent reset allows undervoltage block
// - Other-source window blocks after first return
// - Second incomer uses swapped indices
// - Manual close needs live line, dead bus
`timescale 1ns/1ps
module bts_transfer_logic
    import bts_pkg::*;
#(
    parameter int TICK_CYCLES = BTS_TICK_CYCLES
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [1:0] schemeRole,
    input wire logic [6:0] ownSourceBlockWindow,
    input wire logic [6:0] dualReturnHoldWindow,
    input wire logic doubleLossTripInhibit,
    input wire logic [1:0] tripChoiceSwitch,
    input wire logic [2:0] breakerConnected,
    input wire logic [2:0] breakerClosed,
    input wire logic [1:0] transformerLockoutSignal,
    input wire logic [1:0] upstreamBreakerTripSignal,
    input wire logic [1:0] inverseLineUndervoltage,
    input wire logic [1:0] definiteLineUndervoltage,
    input wire logic [1:0] phaseInstantOvercurrent,
    input wire logic [1:0] neutralInstantOvercurrent,
    input wire logic closeRequestIn,
    input wire logic transferInhibitInput,
    input wire logic syncCheckPermit,
    input wire logic lineLive,
    input wire logic busDead,
    output logic ownTrip,
    output logic closeRequestOut,
    output logic tieClose,
    output logic manualClosePermit,
    output logic transferBusy
);
    localparam int NIN = 15;

    logic [NIN-1:0] rawIn;
    logic [NIN-1:0] syncA;
    logic [NIN-1:0] syncB;
    logic [NIN-1:0] syncC;
    logic [NIN-1:0] cleanIn;
    logic tick;
    logic isInc;
    logic isTie;
    logic active;
    logic [2:0] brkConn;
    logic [2:0] brkClosed;
    logic [2:0] brkClosedQ;
    logic ownOc;
    logic ownOcQ;
    logic ocReset;
    logic thisWin;
    logic [1:0] srcLost;
    logic [1:0] srcLostQ;
    logic doubleLoss;
    logic firstReturn;
    logic otherWin;
    logic initCause;
    logic blocked;
    logic timedUvTrip;
    logic tieLatch;
    logic parallelTrip;
    logic ownIdx;
    logic othIdx;
    bts_state_t state;
    bts_state_t next_state;
    bts_role_t role;

    assign role = bts_role_t'(schemeRole);
    assign rawIn = {breakerConnected, breakerClosed, transformerLockoutSignal,
                    upstreamBreakerTripSignal, inverseLineUndervoltage, definiteLineUndervoltage, closeRequestIn};

    // Three-stage pin synchronisers; stage one feeds only stage two
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            syncA <= '0;
            syncB <= '0;
            syncC <= '0;
            cleanIn <= '0;
        end else begin
            syncA <= rawIn;
            syncB <= syncA;
            syncC <= syncB;
            for (int i = 0; i < NIN; i++) begin
                if (syncB[i] == syncC[i]) begin
                    cleanIn[i] <= syncC[i];
                end
            end
        end
    end

    bts_tick_gen #(
        .CYCLES(TICK_CYCLES)
    ) u_tick (
        .clock(clock),
        .sys_rst(sys_rst),
        .tick(tick)
    );

    // Role decode and index swap for the second incomer
    assign isInc = (role == BTS_ROLE_INC1) || (role == BTS_ROLE_INC2);
    assign isTie = (role == BTS_ROLE_TIE);
    assign active = (role != BTS_ROLE_OFF);
    assign ownIdx = (role == BTS_ROLE_INC2);
    assign othIdx = ~ownIdx;

    assign brkConn = cleanIn[14:12];
    assign brkClosed = cleanIn[11:9];

    // Overcurrent elements are internal, same clock, used directly
    assign ownOc = phaseInstantOvercurrent[ownIdx] | neutralInstantOvercurrent[ownIdx];
    assign ocReset = ownOcQ && !ownOc;

    // Source lost means timed undervoltage on that line
    assign srcLost = cleanIn[4:3];
    assign doubleLoss = &srcLost;
    assign firstReturn = (&srcLostQ) && (srcLost != 2'b11) && (srcLost != 2'b00);

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ownOcQ <= 1'b0;
            srcLostQ <= 2'b00;
            brkClosedQ <= 3'h0;
        end else begin
            ownOcQ <= ownOc;
            srcLostQ <= srcLost;
            brkClosedQ <= brkClosed;
        end
    end

    bts_guard_timer u_this_win (
        .clock(clock),
        .sys_rst(sys_rst),
        .tick(tick),
        .start(ocReset),
        .setting(ownSourceBlockWindow),
        .running(thisWin)
    );

    bts_guard_timer u_other_win (
        .clock(clock),
        .sys_rst(sys_rst),
        .tick(tick),
        .start(firstReturn),
        .setting(dualReturnHoldWindow),
        .running(otherWin)
    );

    // Initiation causes on the own source
    assign initCause = cleanIn[7 + 32'(ownIdx)] | cleanIn[5 + 32'(ownIdx)] | cleanIn[3 + 32'(ownIdx)];

    // Any blocking condition stops a new transfer; the undervoltage block stays armed
    // during the this-source window because a fault dip can look like a healthy-source loss
    assign blocked = !(&brkConn)
        || !brkClosed[othIdx]
        || ownOc
        || cleanIn[1 + 32'(othIdx)]
        || (thisWin && cleanIn[1 + 32'(ownIdx)])
        || otherWin
        || doubleLoss;

    // Plain timed undervoltage trip on double loss unless inhibited
    assign timedUvTrip = doubleLoss && cleanIn[3 + 32'(ownIdx)] && !doubleLossTripInhibit;

    // Incomer sequence: hold trip until own breaker reports open
    always_comb begin
        next_state = state;
        unique case (state)
            BTS_ST_IDLE: begin
                if (isInc && initCause && !blocked) begin
                    next_state = BTS_ST_XFER;
                end
            end
            BTS_ST_XFER: begin
                if (!brkClosed[ownIdx]) begin
                    next_state = BTS_ST_DONE;
                end
            end
            BTS_ST_DONE: begin
                if (!initCause) begin
                    next_state = BTS_ST_IDLE;
                end
            end
            default: next_state = BTS_ST_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst || !isInc) begin
            state <= BTS_ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Tie latch: held until tie closes or inhibit; set wins only when neither ends it
    always_ff @(posedge clock) begin
        if (sys_rst || !isTie) begin
            tieLatch <= 1'b0;
        end else if (brkClosed[2] || transferInhibitInput) begin
            tieLatch <= 1'b0;
        end else if (cleanIn[0]) begin
            tieLatch <= 1'b1;
        end
    end

    // Prevent parallel: a breaker closing while the other two were already closed and still are;
    // breakers rising together after reset or in a swap do not count as a third closing
    always_comb begin
        parallelTrip = 1'b0;
        for (int b = 0; b < 3; b++) begin
            if (brkClosed[b] && !brkClosedQ[b]
                && (brkClosed & brkClosedQ & ~(3'h1 << b)) == (3'h7 & ~(3'h1 << b))) begin
                parallelTrip = 1'b1;
            end
        end
    end

    logic parallelHold;
    logic chosenForTrip;

    // Chosen breaker is this relay's own breaker per the selector
    always_comb begin
        unique case (role)
            BTS_ROLE_INC1: chosenForTrip = (tripChoiceSwitch == BTS_SEL_INC1);
            BTS_ROLE_INC2: chosenForTrip = (tripChoiceSwitch == BTS_SEL_INC2);
            BTS_ROLE_TIE: chosenForTrip = (tripChoiceSwitch == BTS_SEL_TIE);
            BTS_ROLE_OFF: chosenForTrip = 1'b0;
        endcase
    end

    // Parallel trip holds until the own breaker opens
    always_ff @(posedge clock) begin
        if (sys_rst || !active) begin
            parallelHold <= 1'b0;
        end else if (parallelTrip && chosenForTrip) begin
            parallelHold <= 1'b1;
        end else if (!brkClosed[isTie ? 2 : 32'(ownIdx)]) begin
            parallelHold <= 1'b0;
        end
    end

    // Registered outputs; the inactive role drives everything low
    always_ff @(posedge clock) begin
        if (sys_rst || !active) begin
            ownTrip <= 1'b0;
            closeRequestOut <= 1'b0;
            tieClose <= 1'b0;
            manualClosePermit <= 1'b0;
            transferBusy <= 1'b0;
        end else begin
            ownTrip <= (state == BTS_ST_XFER) || parallelHold || (isInc && timedUvTrip);
            closeRequestOut <= (state == BTS_ST_XFER);
            tieClose <= tieLatch && syncCheckPermit && !doubleLoss;
            manualClosePermit <= isInc && !brkClosed[ownIdx] && lineLive && busDead;
            transferBusy <= (state != BTS_ST_IDLE) || tieLatch;
        end
    end

    // Trip holds for the whole transfer until the breaker opens
    property p_hold_trip;
        @(posedge clock) disable iff (sys_rst)
        (state == BTS_ST_XFER) && active |=> ownTrip && closeRequestOut;
    endproperty
    a_hold_trip: assert property (p_hold_trip) else $error("trip not held in transfer");

    property p_inactive;
        @(posedge clock) disable iff (sys_rst)
        !active |=> !ownTrip && !closeRequestOut && !tieClose;
    endproperty
    a_inactive: assert property (p_inactive) else $error("inactive role drove output");

    property p_tie_permit;
        @(posedge clock) disable iff (sys_rst)
        tieClose |-> $past(syncCheckPermit) && $past(tieLatch);
    endproperty
    a_tie_permit: assert property (p_tie_permit) else $error("tie close without permit");

    property p_tie_clear;
        @(posedge clock) disable iff (sys_rst)
        isTie && transferInhibitInput |=> !tieLatch;
    endproperty
    a_tie_clear: assert property (p_tie_clear) else $error("latch kept after inhibit");

    property p_no_init_blocked;
        @(posedge clock) disable iff (sys_rst)
        (state == BTS_ST_IDLE) && blocked |=> state == BTS_ST_IDLE;
    endproperty
    a_no_init_blocked: assert property (p_no_init_blocked) else $error("transfer while blocked");

    property p_double_loss;
        @(posedge clock) disable iff (sys_rst)
        doubleLoss ##1 doubleLoss |-> !tieClose;
    endproperty
    a_double_loss: assert property (p_double_loss) else $error("tie closed on double loss");

    property p_manual;
        @(posedge clock) disable iff (sys_rst)
        manualClosePermit |-> $past(lineLive) && $past(busDead);
    endproperty
    a_manual: assert property (p_manual) else $error("manual close without live-dead");

    property p_release;
        @(posedge clock) disable iff (sys_rst)
        (state == BTS_ST_XFER) && !brkClosed[ownIdx] && isInc |=> state == BTS_ST_DONE;
    endproperty
    a_release: assert property (p_release) else $error("transfer not released");

    // A held parallel trip reaches the trip output on the next edge
    property p_parallel_trip;
        @(posedge clock) disable iff (sys_rst)
        parallelHold && active |=> ownTrip;
    endproperty
    a_parallel_trip: assert property (p_parallel_trip) else $error("parallel trip not driven");

    property p_dl_inhibit;
        @(posedge clock) disable iff (sys_rst)
        doubleLossTripInhibit && (state == BTS_ST_IDLE) && !parallelHold |=> !ownTrip;
    endproperty
    a_dl_inhibit: assert property (p_dl_inhibit) else $error("timed trip while inhibited");

    property p_other_open;
        @(posedge clock) disable iff (sys_rst)
        (state == BTS_ST_IDLE) && !brkClosed[othIdx] |=> state == BTS_ST_IDLE;
    endproperty
    a_other_open: assert property (p_other_open) else $error("transfer with other incomer open");

    c_transfer: cover property (@(posedge clock) disable iff (sys_rst) state == BTS_ST_XFER);
    c_tie_close: cover property (@(posedge clock) disable iff (sys_rst) tieClose);
    c_parallel: cover property (@(posedge clock) disable iff (sys_rst) parallelHold);
endmodule

// [verilog/bts_pkg.sv]
// Package with roles, timing and reset constants for the bus transfer scheme
package bts_pkg;
    // Breaker role chosen by the scheme role setting
    typedef enum logic [1:0] {
        BTS_ROLE_OFF  = 2'h0,
        BTS_ROLE_INC1 = 2'h1,
        BTS_ROLE_INC2 = 2'h2,
        BTS_ROLE_TIE  = 2'h3
    } bts_role_t;

    // Trip selector positions
    typedef enum logic [1:0] {
        BTS_SEL_INC1 = 2'h0,
        BTS_SEL_INC2 = 2'h1,
        BTS_SEL_TIE  = 2'h2
    } bts_sel_t;

    // Incomer transfer sequence, Gray coded from IDLE through XFER to DONE
    typedef enum logic [1:0] {
        BTS_ST_IDLE = 2'h0,
        BTS_ST_XFER = 2'h1,
        BTS_ST_DONE = 2'h3
    } bts_state_t;

    localparam int BTS_CLK_HZ = 50000000;
    localparam int BTS_TICK_MS = 100;
    localparam int BTS_TICK_CYCLES = BTS_CLK_HZ / 1000 * BTS_TICK_MS;
    localparam int BTS_DELAY_W = 7;
    localparam logic [6:0] BTS_DELAY_MAX = 7'h64;
    localparam logic [6:0] BTS_DELAY_RST = 7'h00;
    localparam int BTS_SYNC_STAGES = 3;
endpackage

// [verilog/bts_tick_gen.sv]
// Divider giving a one-cycle pulse every tick period
`timescale 1ns/1ps
module bts_tick_gen
    import bts_pkg::*;
#(
    parameter int CYCLES = BTS_TICK_CYCLES
) (
    input wire logic clock,
    input wire logic sys_rst,
    output logic tick
);
    logic [31:0] count;

    // Free-running divider; tick is registered so it is glitch free
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            count <= 32'h0;
            tick <= 1'b0;
        end else if (count >= 32'(CYCLES - 1)) begin
            count <= 32'h0;
            tick <= 1'b1;
        end else begin
            count <= count + 32'h1;
            tick <= 1'b0;
        end
    end
endmodule

// [verilog/bts_guard_timer.sv]
// Guard delay timer counting ticks, restarts on every start
`timescale 1ns/1ps
module bts_guard_timer
    import bts_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic tick,
    input wire logic start,
    input wire logic [6:0] setting,
    output logic running
);
    logic [6:0] count;
    logic [6:0] limit;

    // Settings above ten seconds are clamped to ten
    assign limit = (setting > BTS_DELAY_MAX) ? BTS_DELAY_MAX : setting;

    // Restart from zero whenever start recurs
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            count <= BTS_DELAY_RST;
            running <= 1'b0;
        end else if (start) begin
            count <= BTS_DELAY_RST;
            running <= (limit != BTS_DELAY_RST);
        end else if (running && tick) begin
            if (count + 7'h01 >= limit) begin
                running <= 1'b0;
            end
            count <= count + 7'h01;
        end
    end
endmodule

// [test/bts_switchgear_model.sv]
// Model of the three breakers and their position contacts
`timescale 1ns/1ps
module bts_switchgear_model #(
    parameter int DELAY = 5
) (
    input wire logic clock,
    input wire logic [2:0] openCmd,
    input wire logic [2:0] closeCmd,
    output logic [2:0] closed
);
    int cnt [3];
    initial begin
        closed = 3'h3;
        cnt = '{0, 0, 0};
    end
    // A breaker moves only after its command has stood DELAY cycles; open wins over close
    always @(posedge clock) begin
        for (int i = 0; i < 3; i++) begin
            if ((openCmd[i] && closed[i]) || (closeCmd[i] && !openCmd[i] && !closed[i])) begin
                if (cnt[i] == DELAY - 1) begin
                    closed[i] <= ~closed[i];
                    cnt[i] <= 0;
                end else begin
                    cnt[i] <= cnt[i] + 1;
                end
            end else begin
                cnt[i] <= 0;
            end
        end
    end
endmodule

// [test/tb.sv]
// Self-checking bench for the bus transfer logic
`timescale 1ns/1ps
module tb;
    import bts_pkg::*;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic [1:0] role = 2'h0, tripSel = 2'h2;
    logic [6:0] winOwn = 7'h00, winDual = 7'h00;
    logic inhibit = 1'b0, closeReq = 1'b0, xferInh = 1'b0, permit = 1'b0, live = 1'b0, dead = 1'b0;
    logic [2:0] conn = 3'h7, tbOpen = 3'h0, tbClose = 3'h0, closed, ownBit;
    logic [1:0] lock = 2'h0, upTrip = 2'h0, invUv = 2'h0, defUv = 2'h0, phOc = 2'h0, nOc = 2'h0;
    logic ownTrip, closeRequestOut, tieClose, manualClosePermit, transferBusy;
    logic [3:0] outs;
    int fail_count = 0;
    int comparisons = 0;
    always #10 clock = ~clock;
    assign outs = {manualClosePermit, tieClose, closeRequestOut, ownTrip};
    assign ownBit = (role == 2'h1) ? 3'h1 : (role == 2'h2) ? 3'h2 : (role == 2'h3) ? 3'h4 : 3'h0;

    bts_switchgear_model #(.DELAY(5)) gear (.clock(clock), .openCmd(tbOpen | (ownTrip ? ownBit : 3'h0)),
        .closeCmd(tbClose | {tieClose, 2'h0}), .closed(closed));

    bts_transfer_logic #(.TICK_CYCLES(10)) dut (.clock(clock), .sys_rst(sys_rst), .schemeRole(role),
        .ownSourceBlockWindow(winOwn), .dualReturnHoldWindow(winDual), .doubleLossTripInhibit(inhibit),
        .tripChoiceSwitch(tripSel), .breakerConnected(conn), .breakerClosed(closed),
        .transformerLockoutSignal(lock), .upstreamBreakerTripSignal(upTrip), .inverseLineUndervoltage(invUv),
        .definiteLineUndervoltage(defUv), .phaseInstantOvercurrent(phOc), .neutralInstantOvercurrent(nOc),
        .closeRequestIn(closeReq), .transferInhibitInput(xferInh), .syncCheckPermit(permit),
        .lineLive(live), .busDead(dead), .ownTrip(ownTrip), .closeRequestOut(closeRequestOut),
        .tieClose(tieClose), .manualClosePermit(manualClosePermit), .transferBusy(transferBusy));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask

    // Bounded wait for one output to reach a level
    task automatic wait_out(input int idx, input logic exp, input int n);
        int k;
        k = 0;
        while (outs[idx] !== exp && k < n) begin
            @(posedge clock);
            k++;
        end
        check({7'h00, outs[idx]}, {7'h00, exp});
    endtask

    // An output must keep one level for n cycles; any deviation is reported once
    task automatic hold_out(input int idx, input logic exp, input int n);
        logic seen;
        seen = exp;
        repeat (n) begin
            @(posedge clock);
            if (outs[idx] !== exp) seen = outs[idx];
        end
        check({7'h00, seen}, {7'h00, exp});
    endtask

    // Drive breakers to a wanted position through the model
    task automatic brk(input logic [2:0] want);
        tbOpen <= ~want;
        tbClose <= want;
        cyc(8);
        tbOpen <= 3'h0;
        tbClose <= 3'h0;
        cyc(6);
    endtask

    // Remove the causes first and the blocks only once the causes have passed the
    // synchronisers, so a block never lifts while a stale cause is still on its way
    task automatic quiet;
        lock <= 2'h0;
        upTrip <= 2'h0;
        invUv <= 2'h0;
        cyc(6);
        defUv <= 2'h0;
        phOc <= 2'h0;
        nOc <= 2'h0;
        conn <= 3'h7;
        cyc(14);
    endtask

    task automatic give_verdict;
        if (fail_count == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // The tests take under two thousand cycles; this allows several times that
    initial begin
        #200000;
        fail_count++;
        give_verdict();
    end

    initial begin
        cyc(10);
        sys_rst <= 1'b0;
        cyc(2);
        check({4'h0, outs}, 8'h00);
        // Each cause on each incomer role trips and requests tie close until own breaker opens
        for (int r = 1; r <= 2; r++) begin
            for (int c = 0; c < 3; c++) begin
                role <= r[1:0];
                brk(3'h3);
                if (c == 0) lock[r - 1] <= 1'b1;
                if (c == 1) upTrip[r - 1] <= 1'b1;
                if (c == 2) invUv[r - 1] <= 1'b1;
                wait_out(0, 1'b1, 12);
                check({7'h00, closeRequestOut}, 8'h01);
                cyc(2);
                check({6'h00, ownTrip, closeRequestOut}, 8'h03);
                check({7'h00, transferBusy}, 8'h01);
                wait_out(1, 1'b0, 30);
                quiet();
            end
        end
        // Connection, other-incomer-open, overcurrent and other-source undervoltage blocks stop initiation
        role <= 2'h1;
        for (int b = 0; b < 5; b++) begin
            brk(b == 1 ? 3'h1 : 3'h3);
            if (b == 0) conn <= 3'h3;
            if (b == 2) phOc[0] <= 1'b1;
            if (b == 3) nOc[0] <= 1'b1;
            if (b == 4) defUv[1] <= 1'b1;
            cyc(1);
            lock[0] <= 1'b1;
            hold_out(0, 1'b0, 14);
            quiet();
        end
        // Own definite undervoltage blocks only inside the window after an overcurrent resets
        winOwn <= 7'h03;
        brk(3'h3);
        phOc[0] <= 1'b1;
        cyc(2);
        phOc[0] <= 1'b0;
        defUv[0] <= 1'b1;
        lock[0] <= 1'b1;
        hold_out(0, 1'b0, 18);
        wait_out(0, 1'b1, 30);
        quiet();
        winOwn <= 7'h00;
        // After a double loss the first source return opens a window that forbids transfer
        winDual <= 7'h03;
        inhibit <= 1'b1;
        brk(3'h3);
        invUv <= 2'h3;
        cyc(6);
        invUv <= 2'h2;
        cyc(2);
        lock[0] <= 1'b1;
        hold_out(0, 1'b0, 18);
        wait_out(0, 1'b1, 30);
        quiet();
        winDual <= 7'h00;
        inhibit <= 1'b0;
        // Inactive role ignores lockout and upstream trip causes
        role <= 2'h0;
        brk(3'h3);
        lock <= 2'h3;
        upTrip <= 2'h3;
        hold_out(0, 1'b0, 14);
        check({7'h00, closeRequestOut}, 8'h00);
        quiet();
        // Double source loss: timed trip only without inhibit, never a close request
        role <= 2'h1;
        for (int i = 0; i < 2; i++) begin
            brk(3'h3);
            inhibit <= i[0];
            invUv <= 2'h3;
            if (i == 0) wait_out(0, 1'b1, 14);
            else hold_out(0, 1'b0, 14);
            hold_out(1, 1'b0, 10);
            quiet();
        end
        inhibit <= 1'b0;
        // Closing a third breaker trips the one chosen by the selector
        tripSel <= 2'h0;
        brk(3'h6);
        tbClose <= 3'h1;
        wait_out(0, 1'b1, 20);
        tbClose <= 3'h0;
        cyc(20);
        // Manual close needs a live line and a dead bus
        brk(3'h6);
        for (int m = 0; m < 4; m++) begin
            live <= m[1];
            dead <= m[0];
            cyc(6);
            check({7'h00, manualClosePermit}, {7'h00, m == 3});
        end
        // Tie latches the request and closes only with permission
        role <= 2'h3;
        brk(3'h3);
        closeReq <= 1'b1;
        hold_out(2, 1'b0, 10);
        closeReq <= 1'b0;
        cyc(4);
        permit <= 1'b1;
        wait_out(2, 1'b1, 6);
        wait_out(2, 1'b0, 20);
        permit <= 1'b0;
        brk(3'h3);
        closeReq <= 1'b1;
        cyc(6);
        closeReq <= 1'b0;
        xferInh <= 1'b1;
        cyc(6);
        xferInh <= 1'b0;
        permit <= 1'b1;
        hold_out(2, 1'b0, 10);
        check({7'h00, transferBusy}, 8'h00);
        give_verdict();
    end
endmodule
